// ===== core/core_irq_pkg.sv
package core_irq_pkg;

   // register indices; byte address is four times the index
   localparam logic [8:0] IEF_IDX_BANK0      = 9'h00b;
   localparam logic [8:0] IEF_IDX_BANK1      = 9'h08b;
   localparam logic [8:0] IEF_IDX_BANK2      = 9'h10b;
   localparam logic [8:0] IEF_IDX_BANK3      = 9'h18b;
   localparam logic [8:0] OPTION_IDX_BANK1   = 9'h081;
   localparam logic [8:0] OPTION_IDX_BANK3   = 9'h181;
   localparam logic [8:0] TIMER_ZERO_IDX     = 9'h001;
   localparam logic [8:0] PORT_B_IDX         = 9'h006;
   localparam logic [8:0] PORT_B_DIR_IDX     = 9'h086;
   localparam logic [8:0] EVENT_STATUS_IDX   = 9'h0f0;
   localparam logic [8:0] EVENT_MASK_IDX     = 9'h0f1;

   // interrupt_enable_flags fields
   localparam int GLOBAL_IRQ_ENABLE_BIT      = 7;
   localparam int PERIPHERAL_IRQ_ENABLE_BIT  = 6;
   localparam int TIMER_OVERFLOW_IRQ_EN_BIT  = 5;
   localparam int EXT_PIN_IRQ_ENABLE_BIT     = 4;
   localparam int PORT_CHANGE_IRQ_EN_BIT     = 3;
   localparam int TIMER_OVERFLOW_FLAG_BIT    = 2;
   localparam int EXT_PIN_IRQ_FLAG_BIT       = 1;
   localparam int PORT_CHANGE_FLAG_BIT       = 0;

   // option_config fields
   localparam int PULLUP_DISABLE_N_BIT       = 7;
   localparam int EXT_IRQ_EDGE_SEL_BIT       = 6;
   localparam int TIMER_CLOCK_SOURCE_BIT     = 5;
   localparam int TIMER_SOURCE_EDGE_BIT      = 4;
   localparam int PRESCALER_ASSIGN_BIT       = 3;
   localparam int PRESCALE_RATE_LSB          = 0;
   localparam int PRESCALE_RATE_WIDTH        = 3;

   // event status and mask fields
   localparam int EVENT_TIMER_BIT            = 0;
   localparam int EVENT_EXT_PIN_BIT          = 1;
   localparam int EVENT_PORT_CHANGE_BIT      = 2;
   localparam int EVENT_WATCHDOG_BIT         = 3;
   localparam int EVENT_WIDTH                = 4;

   // reset values
   localparam logic [7:0] IEF_RESET          = 8'h00;
   localparam logic [7:0] OPTION_RESET       = 8'hff;
   localparam logic [7:0] PORT_B_DIR_RESET   = 8'hff;
   localparam logic [7:0] PORT_B_LATCH_RESET = 8'h00;
   localparam logic [7:0] TIMER_ZERO_RESET   = 8'h00;
   localparam logic [3:0] EVENT_MASK_RESET   = 4'h0;

   // timing
   localparam int CLK_PERIOD_NS              = 5;
   localparam int INSTR_CYCLE_DIV            = 4;
   localparam int WATCHDOG_PERIOD_US         = 18;
   localparam int WATCHDOG_BASE_CYCLES       = WATCHDOG_PERIOD_US * 1000 / CLK_PERIOD_NS;

endpackage : core_irq_pkg

// ===== core/core_irq_prescale_port_b_a.sv
// Local design decision: the APB register port.
`timescale 1ns/1ps
module core_irq_prescale_port_b_a #(
   parameter int unsigned WATCHDOG_BASE_CYCLES = core_irq_pkg::WATCHDOG_BASE_CYCLES
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [31:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [7:0]  port_b_in,
   output logic      [7:0]  port_b_out,
   output logic      [7:0]  port_b_oe_n,
   output logic      [7:0]  port_b_pullup_en,
   input  wire logic        external_timer_clock_pin,
   input  wire logic        periph_irq_req,
   input  wire logic        watchdog_enable,
   input  wire logic        watchdog_clear,
   output logic             instruction_cycle_clock,
   output logic             watchdog_timeout,
   output logic             core_irq,
   output logic             event_irq
);
   logic [7:0]  interrupt_enable_flags;
   logic [7:0]  option_config;
   logic [7:0]  port_b_a_direction;
   logic [7:0]  port_b_latch;
   logic [7:0]  timer_zero;
   logic [3:0]  event_status;
   logic [3:0]  event_mask;
   logic [1:0]  instr_cnt;
   logic [31:0] watchdog_cnt;
   logic [8:0]  pin_q;
   logic [8:0]  pin_prev;
   logic [8:0]  pin_rise;
   logic [8:0]  pin_fall;
   logic [3:0]  change_ref;
   logic        mismatch_prev;
   logic        mismatch;
   logic [8:0]  idx;
   logic        addr_hit;
   logic [7:0]  rd_byte;
   logic        setup_phase;
   logic        wr_en;
   logic        rd_done;
   logic [7:0]  wbyte;
   logic        timer_src_tick;
   logic        watchdog_base_tick;
   logic        presc_in;
   logic        presc_out;
   logic        presc_clear;
   logic        timer_inc;
   logic        timer_overflow;
   logic        ext_edge;
   logic        change_event;
   logic [3:0]  events;
   logic        to_watchdog;
   logic [2:0]  settle;
   logic        settled;

   function automatic logic is_option(input logic [8:0] i);
      return (i == core_irq_pkg::OPTION_IDX_BANK1) || (i == core_irq_pkg::OPTION_IDX_BANK3);
   endfunction : is_option

   function automatic logic is_ief(input logic [8:0] i);
      return (i == core_irq_pkg::IEF_IDX_BANK0) || (i == core_irq_pkg::IEF_IDX_BANK1) ||
             (i == core_irq_pkg::IEF_IDX_BANK2) || (i == core_irq_pkg::IEF_IDX_BANK3);
   endfunction : is_ief

   // bus decode
   assign idx         = paddr[10:2];
   assign setup_phase = psel && !penable;
   assign pready      = 1'b1;
   assign wbyte       = pwdata[7:0];
   assign wr_en       = psel && penable && pwrite && pstrb[0] && addr_hit;
   assign rd_done     = psel && penable && !pwrite && addr_hit;

   always_comb begin
      addr_hit = (paddr[31:11] == 21'h000000) && (paddr[1:0] == 2'h0);
      rd_byte  = 8'h00;
      if (is_option(idx)) begin
         rd_byte = option_config;
      end else if (is_ief(idx)) begin
         rd_byte = interrupt_enable_flags;
      end else if (idx == core_irq_pkg::TIMER_ZERO_IDX) begin
         rd_byte = timer_zero;
      end else if (idx == core_irq_pkg::PORT_B_IDX) begin
         rd_byte = pin_q[7:0];
      end else if (idx == core_irq_pkg::PORT_B_DIR_IDX) begin
         rd_byte = port_b_a_direction;
      end else if (idx == core_irq_pkg::EVENT_STATUS_IDX) begin
         rd_byte = {4'h0, event_status};
      end else if (idx == core_irq_pkg::EVENT_MASK_IDX) begin
         rd_byte = {4'h0, event_mask};
      end else begin
         addr_hit = 1'b0;
      end
   end

   // answer captured in setup so prdata comes from flops with no wait state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
      end else if (setup_phase) begin
         prdata  <= {24'h000000, rd_byte};
         pslverr <= !addr_hit;
      end
   end

   // instruction cycle enable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         instr_cnt <= 2'h0;
      end else if (instr_cnt == 2'(core_irq_pkg::INSTR_CYCLE_DIV - 1)) begin
         instr_cnt <= 2'h0;
      end else begin
         instr_cnt <= 2'(instr_cnt + 2'h1);
      end
   end
   assign instruction_cycle_clock = (instr_cnt == 2'(core_irq_pkg::INSTR_CYCLE_DIV - 1));

   // pins: port B in bits 7:0, timer clock pin in bit 8
   pin_sync #(.WIDTH(9)) u_pin_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .d       ({external_timer_clock_pin, port_b_in}),
      .q       (pin_q)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_prev <= 9'h000;
      end else begin
         pin_prev <= pin_q;
      end
   end

   // the synchroniser reads zero until it fills
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         settle <= 3'h0;
      end else if (!settled) begin
         settle <= 3'(settle + 3'h1);
      end
   end
   assign settled = &settle;
   // no false edge from a pin already high at reset
   assign pin_rise = pin_q & ~pin_prev & {9{settled}};
   assign pin_fall = ~pin_q & pin_prev & {9{settled}};

   // configuration registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         option_config <= core_irq_pkg::OPTION_RESET;
      end else if (wr_en && is_option(idx)) begin
         option_config <= wbyte;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_b_a_direction <= core_irq_pkg::PORT_B_DIR_RESET;
         port_b_latch    <= core_irq_pkg::PORT_B_LATCH_RESET;
      end else if (wr_en && idx == core_irq_pkg::PORT_B_DIR_IDX) begin
         port_b_a_direction <= wbyte;
      end else if (wr_en && idx == core_irq_pkg::PORT_B_IDX) begin
         port_b_latch <= wbyte;
      end
   end

   // port B pads: oe_n low drives the latch, high leaves the pin to the outside
   assign port_b_out       = port_b_latch;
   assign port_b_oe_n      = port_b_a_direction;
   assign port_b_pullup_en = {8{!option_config[core_irq_pkg::PULLUP_DISABLE_N_BIT]}}
                             & port_b_a_direction;

   // timer source: instruction cycles or a pin edge
   always_comb begin
      if (option_config[core_irq_pkg::TIMER_CLOCK_SOURCE_BIT]) begin
         timer_src_tick = option_config[core_irq_pkg::TIMER_SOURCE_EDGE_BIT] ? pin_fall[8]
                                                                             : pin_rise[8];
      end else begin
         timer_src_tick = instruction_cycle_clock;
      end
   end

   // watchdog base period; cleared by the core so firmware can keep it quiet
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         watchdog_cnt <= 32'h00000000;
      end else if (watchdog_clear || !watchdog_enable || watchdog_base_tick) begin
         watchdog_cnt <= 32'h00000000;
      end else begin
         watchdog_cnt <= 32'(watchdog_cnt + 32'h00000001);
      end
   end
   assign watchdog_base_tick = watchdog_enable && !watchdog_clear &&
                               (watchdog_cnt == 32'(WATCHDOG_BASE_CYCLES - 1));

   // the one prescaler sits in front of whichever user it is assigned to
   assign to_watchdog = option_config[core_irq_pkg::PRESCALER_ASSIGN_BIT];
   assign presc_in    = to_watchdog ? watchdog_base_tick : timer_src_tick;
   // switching owners restarts the count so no partial count leaks across
   assign presc_clear = (wr_en && is_option(idx) &&
                         wbyte[core_irq_pkg::PRESCALER_ASSIGN_BIT] != to_watchdog) ||
                        (to_watchdog && watchdog_clear) ||
                        (!to_watchdog && wr_en && idx == core_irq_pkg::TIMER_ZERO_IDX);

   shared_prescaler u_prescaler (
      .pclk        (pclk),
      .presetn     (presetn),
      .tick_in     (presc_in),
      .clear       (presc_clear),
      .rate_sel    (option_config[core_irq_pkg::PRESCALE_RATE_LSB +: core_irq_pkg::PRESCALE_RATE_WIDTH]),
      .to_watchdog (to_watchdog),
      .tick_out    (presc_out)
   );

   assign timer_inc        = to_watchdog ? timer_src_tick : presc_out;
   assign watchdog_timeout = to_watchdog ? presc_out : watchdog_base_tick;

   // timer zero; a write takes priority over a count in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_zero <= core_irq_pkg::TIMER_ZERO_RESET;
      end else if (wr_en && idx == core_irq_pkg::TIMER_ZERO_IDX) begin
         timer_zero <= wbyte;
      end else if (timer_inc) begin
         timer_zero <= 8'(timer_zero + 8'h01);
      end
   end
   assign timer_overflow = timer_inc && (timer_zero == 8'hff) &&
                           !(wr_en && idx == core_irq_pkg::TIMER_ZERO_IDX);

   // external pin edge on port B pin 0
   assign ext_edge = option_config[core_irq_pkg::EXT_IRQ_EDGE_SEL_BIT] ? pin_rise[0]
                                                                       : pin_fall[0];

   // port change: input pins 7:4 against the value seen at the last port read
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         change_ref <= 4'h0;
      end else if (rd_done && idx == core_irq_pkg::PORT_B_IDX) begin
         change_ref <= prdata[7:4];
      end
   end
   assign mismatch = |((pin_q[7:4] ^ change_ref) & port_b_a_direction[7:4]);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mismatch_prev <= 1'b0;
      end else begin
         mismatch_prev <= mismatch;
      end
   end
   // pins high at reset do not count as a change
   assign change_event = mismatch && !mismatch_prev && settled;

   // enables follow the write; flags are set by events with set beating a clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         interrupt_enable_flags <= core_irq_pkg::IEF_RESET;
      end else begin
         if (wr_en && is_ief(idx)) begin
            interrupt_enable_flags <= wbyte;
         end
         if (timer_overflow) begin
            interrupt_enable_flags[core_irq_pkg::TIMER_OVERFLOW_FLAG_BIT] <= 1'b1;
         end
         if (ext_edge) begin
            interrupt_enable_flags[core_irq_pkg::EXT_PIN_IRQ_FLAG_BIT] <= 1'b1;
         end
         if (change_event) begin
            interrupt_enable_flags[core_irq_pkg::PORT_CHANGE_FLAG_BIT] <= 1'b1;
         end
      end
   end

   // flags stay set until written to zero
   assign core_irq = interrupt_enable_flags[core_irq_pkg::GLOBAL_IRQ_ENABLE_BIT] && (
      (interrupt_enable_flags[core_irq_pkg::TIMER_OVERFLOW_IRQ_EN_BIT] &&
       interrupt_enable_flags[core_irq_pkg::TIMER_OVERFLOW_FLAG_BIT]) ||
      (interrupt_enable_flags[core_irq_pkg::EXT_PIN_IRQ_ENABLE_BIT] &&
       interrupt_enable_flags[core_irq_pkg::EXT_PIN_IRQ_FLAG_BIT]) ||
      (interrupt_enable_flags[core_irq_pkg::PORT_CHANGE_IRQ_EN_BIT] &&
       interrupt_enable_flags[core_irq_pkg::PORT_CHANGE_FLAG_BIT]) ||
      (interrupt_enable_flags[core_irq_pkg::PERIPHERAL_IRQ_ENABLE_BIT] && periph_irq_req));

   // sticky event status, write one to clear, set wins
   always_comb begin
      events = 4'h0;
      events[core_irq_pkg::EVENT_TIMER_BIT]       = timer_overflow;
      events[core_irq_pkg::EVENT_EXT_PIN_BIT]     = ext_edge;
      events[core_irq_pkg::EVENT_PORT_CHANGE_BIT] = change_event;
      events[core_irq_pkg::EVENT_WATCHDOG_BIT]    = watchdog_timeout;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         event_status <= 4'h0;
      end else if (wr_en && idx == core_irq_pkg::EVENT_STATUS_IDX) begin
         event_status <= (event_status & ~wbyte[3:0]) | events;
      end else begin
         event_status <= event_status | events;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         event_mask <= core_irq_pkg::EVENT_MASK_RESET;
      end else if (wr_en && idx == core_irq_pkg::EVENT_MASK_IDX) begin
         event_mask <= wbyte[3:0];
      end
   end

   assign event_irq = |(event_status & event_mask);
endmodule : core_irq_prescale_port_b_a

// ===== core/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] s1;
   logic [WIDTH-1:0] s2;
   logic [WIDTH-1:0] s3;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
      end else begin
         s1 <= d;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // a bit moves only once the second and third stage agree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
      end else begin
         q <= (s3 & ~(s2 ^ s3)) | (q & (s2 ^ s3));
      end
   end
endmodule : pin_sync

// ===== core/shared_prescaler.sv
`timescale 1ns/1ps
module shared_prescaler (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       tick_in,
   input  wire logic       clear,
   input  wire logic [2:0] rate_sel,
   input  wire logic       to_watchdog,
   output logic            tick_out
);
   logic [6:0] cnt;
   logic [3:0] div_log2;
   logic [6:0] mask;

   // timer ratios start at 1:2, watchdog ratios at 1:1
   always_comb begin
      div_log2 = to_watchdog ? {1'b0, rate_sel} : 4'({1'b0, rate_sel} + 4'h1);
      mask     = 7'((8'h01 << div_log2) - 8'h01);
      tick_out = tick_in && ((cnt & mask) == mask);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= '0;
      end else if (clear) begin
         cnt <= '0;
      end else if (tick_in) begin
         cnt <= 7'(cnt + 7'h01);
      end
   end
endmodule : shared_prescaler

// ===== sim/core_irq_props.sv
`timescale 1ns/1ps
module core_irq_props #(
   parameter int unsigned WATCHDOG_BASE_CYCLES = 20
) (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic [31:0] paddr,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [7:0]  port_b_out,
   input wire logic [7:0]  port_b_oe_n,
   input wire logic [7:0]  port_b_pullup_en,
   input wire logic        instruction_cycle_clock,
   input wire logic        watchdog_timeout,
   input wire logic        core_irq,
   input wire logic        event_irq
);
   wire logic [8:0] idx = paddr[10:2];
   wire logic       al  = (paddr[31:11] == 21'h0) && (paddr[1:0] == 2'b00);
   wire logic       wr  = psel && penable && pwrite && pstrb[0] && al;
   wire logic       su  = psel && !penable;
   wire logic [7:0] wd  = pwdata[7:0];
   wire logic       ic  = idx inside {core_irq_pkg::IEF_IDX_BANK0, core_irq_pkg::IEF_IDX_BANK1,
                                      core_irq_pkg::IEF_IDX_BANK2, core_irq_pkg::IEF_IDX_BANK3};
   wire logic       opt = idx inside {core_irq_pkg::OPTION_IDX_BANK1, core_irq_pkg::OPTION_IDX_BANK3};

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   AST_NO_WAIT: assert property (psel && penable |-> pready)
      else $error("access phase without pready");
   AST_RDATA_UPPER: assert property (prdata[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   AST_OUTPUT_NO_PULLUP: assert property ((port_b_pullup_en & ~port_b_oe_n) == 8'h00)
      else $error("pull-up on a driven pin");
   AST_DIR_WRITE: assert property (wr && idx == core_irq_pkg::PORT_B_DIR_IDX |=> port_b_oe_n == $past(wd))
      else $error("direction write not on enables");
   AST_LATCH_WRITE: assert property (wr && idx == core_irq_pkg::PORT_B_IDX |=> port_b_out == $past(wd))
      else $error("latch write not on outputs");
   AST_PULLUP_OFF: assert property (wr && opt && wd[7] |=> port_b_pullup_en == 8'h00)
      else $error("pull-ups on with disable bit set");
   AST_GLOBAL_OFF: assert property (wr && ic && !wd[7] |=> !core_irq)
      else $error("request with global enable clear");
   AST_MAPPED_OK: assert property (su && al && (ic || opt) |=> !pslverr)
      else $error("error on a mapped address");
   AST_UNALIGNED: assert property (su && paddr[1:0] != 2'b00 |=> pslverr)
      else $error("no error on unaligned address");
   AST_CYCLE_CLOCK: assert property (instruction_cycle_clock |=>
      !instruction_cycle_clock [*3] ##1 instruction_cycle_clock)
      else $error("instruction cycle pulse not every 4 clocks");

   cover property (core_irq);
   cover property (event_irq);
   cover property (watchdog_timeout);
   cover property (pslverr);
endmodule : core_irq_props

bind core_irq_prescale_port_b_a core_irq_props #(.WATCHDOG_BASE_CYCLES(WATCHDOG_BASE_CYCLES)) i_core_irq_props (
   .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata, .pready, .pslverr,
   .port_b_out, .port_b_oe_n, .port_b_pullup_en, .instruction_cycle_clock, .watchdog_timeout,
   .core_irq, .event_irq);

// ===== sim/test_core_irq_prescale_port_b_a.sv
`timescale 1ns/1ps
module test_core_irq_prescale_port_b_a;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
   logic [31:0] paddr, pwdata, prdata;
   logic [3:0]  pstrb;
   logic [7:0]  port_b_in, port_b_out, port_b_oe_n, port_b_pullup_en, q, q0;
   logic        external_timer_clock_pin, periph_irq_req, watchdog_enable, watchdog_clear;
   logic        instruction_cycle_clock, watchdog_timeout, core_irq, event_irq;
   int          mismatches, checks_done;

   // short watchdog base keeps the run small
   core_irq_prescale_port_b_a #(.WATCHDOG_BASE_CYCLES(20)) i_core_irq_prescale_port_b_a (
      .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata, .pready, .pslverr,
      .port_b_in, .port_b_out, .port_b_oe_n, .port_b_pullup_en, .external_timer_clock_pin,
      .periph_irq_req, .watchdog_enable, .watchdog_clear, .instruction_cycle_clock,
      .watchdog_timeout, .core_irq, .event_irq);

   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   task stop_test;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : stop_test

   task chk(input string n, input logic [7:0] x, input logic [7:0] g);
      checks_done++;
      if (g !== x) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", n, x, g);
      end
   endtask : chk

   task lim(input int n);
      if (n >= 300) begin
         mismatches++;
         $display("BAD wait expected end seen timeout");
         stop_test();
      end
   endtask : lim

   // waits a fixed count, then steps off the edge so outputs have settled
   task wt(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask : wt

   task apb(input logic w, input logic [31:0] a, input logic [7:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 300);
      lim(n);
      q = prdata[7:0];
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask : apb

   task wr(input logic [8:0] i, input logic [7:0] d);
      apb(1'b1, {21'h0, i, 2'b00}, d);
   endtask : wr

   task rd(input logic [8:0] i);
      apb(1'b0, {21'h0, i, 2'b00}, 8'h00);
   endtask : rd

   task rdc(input string n, input logic [8:0] i, input logic [7:0] x);
      rd(i);
      chk(n, x, q);
   endtask : rdc

   task pin(input int b, input logic v);
      @(posedge pclk) port_b_in[b] <= v;
      wt(10);
   endtask : pin

   task t_reset;
      rdc("ief", core_irq_pkg::IEF_IDX_BANK0, 8'h00);
      rdc("option", core_irq_pkg::OPTION_IDX_BANK3, 8'hff);
      chk("oe_n", 8'hff, port_b_oe_n);
      chk("pullup", 8'h00, port_b_pullup_en);
      rdc("timer", core_irq_pkg::TIMER_ZERO_IDX, 8'h00);
      $display("t_reset done");
   endtask : t_reset

   task t_mirror;
      wr(core_irq_pkg::IEF_IDX_BANK3, 8'h38);
      rdc("ief b0", core_irq_pkg::IEF_IDX_BANK0, 8'h38);
      rdc("ief b1", core_irq_pkg::IEF_IDX_BANK1, 8'h38);
      rdc("ief b2", core_irq_pkg::IEF_IDX_BANK2, 8'h38);
      wr(core_irq_pkg::OPTION_IDX_BANK3, 8'h5d);
      rdc("option b1", core_irq_pkg::OPTION_IDX_BANK1, 8'h5d);
      chk("pullup on", 8'hff, port_b_pullup_en);
      apb(1'b0, {21'h0, 9'h0f5, 2'b00}, 8'h00);
      chk("unmapped err", 8'h01, {7'h0, e});
      chk("unmapped data", 8'h00, q);
      apb(1'b1, 32'h0000_002d, 8'h11);
      chk("unaligned err", 8'h01, {7'h0, e});
      rdc("ief kept", core_irq_pkg::IEF_IDX_BANK0, 8'h38);
      $display("t_mirror done");
   endtask : t_mirror

   task t_port_b_a;
      wr(core_irq_pkg::OPTION_IDX_BANK1, 8'h08);
      wr(core_irq_pkg::PORT_B_DIR_IDX, 8'hcf);
      chk("oe_n", 8'hcf, port_b_oe_n);
      chk("pullup dir", 8'hcf, port_b_pullup_en);
      wr(core_irq_pkg::PORT_B_IDX, 8'ha5);
      chk("latch", 8'ha5, port_b_out);
      wr(core_irq_pkg::OPTION_IDX_BANK1, 8'h88);
      chk("pullup off", 8'h00, port_b_pullup_en);
      wr(core_irq_pkg::PORT_B_DIR_IDX, 8'hff);
      $display("t_port_b_a done");
   endtask : t_port_b_a

   task t_ext;
      // external timer source with a still pin freezes timer zero
      wr(core_irq_pkg::OPTION_IDX_BANK1, 8'he8);
      wr(core_irq_pkg::IEF_IDX_BANK0, 8'h00);
      pin(0, 1'b1);
      rdc("ext flag", core_irq_pkg::IEF_IDX_BANK0, 8'h02);
      wr(core_irq_pkg::IEF_IDX_BANK0, 8'h12);
      chk("gate off", 8'h00, {7'h0, core_irq});
      wr(core_irq_pkg::IEF_IDX_BANK0, 8'h92);
      chk("gate on", 8'h01, {7'h0, core_irq});
      wr(core_irq_pkg::IEF_IDX_BANK0, 8'h90);
      chk("cleared", 8'h00, {7'h0, core_irq});
      wr(core_irq_pkg::OPTION_IDX_BANK1, 8'ha8);
      pin(0, 1'b0);
      chk("fall irq", 8'h01, {7'h0, core_irq});
      wr(core_irq_pkg::IEF_IDX_BANK0, 8'h10);
      pin(0, 1'b1);
      rdc("no rise", core_irq_pkg::IEF_IDX_BANK0, 8'h10);
      $display("t_ext done");
   endtask : t_ext

   task t_change;
      wr(core_irq_pkg::IEF_IDX_BANK0, 8'h00);
      rdc("pins", core_irq_pkg::PORT_B_IDX, 8'h01);
      pin(7, 1'b1);
      rdc("change flag", core_irq_pkg::IEF_IDX_BANK0, 8'h01);
      wr(core_irq_pkg::IEF_IDX_BANK0, 8'h89);
      chk("change irq", 8'h01, {7'h0, core_irq});
      wr(core_irq_pkg::IEF_IDX_BANK0, 8'h80);
      @(posedge pclk) periph_irq_req <= 1'b1;
      wt(1);
      chk("periph no peripheral_irq_enable", 8'h00, {7'h0, core_irq});
      wr(core_irq_pkg::IEF_IDX_BANK0, 8'hc0);
      chk("periph", 8'h01, {7'h0, core_irq});
      @(posedge pclk) periph_irq_req <= 1'b0;
      $display("t_change done");
   endtask : t_change

   task t_timer;
      for (int r = 0; r < 5; r++) begin
         // rate 4 stands for prescaler on the watchdog, giving 1:1
         wr(core_irq_pkg::OPTION_IDX_BANK1, (r == 4) ? 8'h08 : 8'(r));
         rd(core_irq_pkg::TIMER_ZERO_IDX);
         q0 = q;
         repeat (189) @(posedge pclk);
         rd(core_irq_pkg::TIMER_ZERO_IDX);
         chk("timer rate", (r == 4) ? 8'd48 : 8'(48 >> (r + 1)), q - q0);
      end
      for (int s = 0; s < 2; s++) begin
         wr(core_irq_pkg::OPTION_IDX_BANK1, 8'h28 | 8'(s << 4));
         @(posedge pclk) external_timer_clock_pin <= 1'b0;
         wt(10);
         rd(core_irq_pkg::TIMER_ZERO_IDX);
         q0 = q;
         for (int k = 0; k < 13; k++) begin
            @(posedge pclk) external_timer_clock_pin <= ~k[0];
            repeat (5) @(posedge pclk);
         end
         wt(10);
         rd(core_irq_pkg::TIMER_ZERO_IDX);
         chk("pin edges", 8'(7 - s), q - q0);
      end
      wr(core_irq_pkg::OPTION_IDX_BANK1, 8'h08);
      wr(core_irq_pkg::IEF_IDX_BANK0, 8'h00);
      wr(core_irq_pkg::TIMER_ZERO_IDX, 8'hfe);
      wt(20);
      rdc("overflow flag", core_irq_pkg::IEF_IDX_BANK0, 8'h04);
      $display("t_timer done");
   endtask : t_timer

   task wd_gap(input logic [7:0] x);
      int n, g;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (watchdog_timeout !== 1'b1 && n < 300);
      lim(n);
      g = 0;
      do begin
         @(posedge pclk);
         g++;
      end while (watchdog_timeout !== 1'b1 && g < 300);
      lim(g);
      chk("watchdog gap", x, 8'(g));
   endtask : wd_gap

   task t_watchdog;
      wr(core_irq_pkg::EVENT_MASK_IDX, 8'h08);
      wr(core_irq_pkg::OPTION_IDX_BANK1, 8'h00);
      @(posedge pclk) watchdog_enable <= 1'b1;
      wd_gap(8'd20);
      wr(core_irq_pkg::OPTION_IDX_BANK1, 8'h09);
      wd_gap(8'd40);
      @(posedge pclk) watchdog_enable <= 1'b0;
      wt(1);
      chk("event irq", 8'h01, {7'h0, event_irq});
      wr(core_irq_pkg::EVENT_MASK_IDX, 8'h00);
      chk("masked", 8'h00, {7'h0, event_irq});
      wr(core_irq_pkg::EVENT_MASK_IDX, 8'h08);
      chk("unmasked", 8'h01, {7'h0, event_irq});
      wr(core_irq_pkg::EVENT_STATUS_IDX, 8'h08);
      chk("w1c irq", 8'h00, {7'h0, event_irq});
      rd(core_irq_pkg::EVENT_STATUS_IDX);
      chk("w1c status", 8'h00, q & 8'h08);
      $display("t_watchdog done");
   endtask : t_watchdog

   initial begin
      mismatches = 0;
      checks_done = 0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 32'h0;
      pwdata = 32'h0;
      pstrb = 4'h1;
      port_b_in = 8'h00;
      external_timer_clock_pin = 1'b0;
      periph_irq_req = 1'b0;
      watchdog_enable = 1'b0;
      watchdog_clear = 1'b0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_mirror();
      t_port_b_a();
      t_ext();
      t_change();
      t_timer();
      t_watchdog();
      stop_test();
   end
endmodule : test_core_irq_prescale_port_b_a
